/* design/irq_enable_pkg.sv */
// Register map, field positions and reset values of the interrupt enable bank
package irq_enable_pkg;

  localparam int unsigned NUM_ENABLE_REGS = 4;
  localparam int unsigned ENABLE_W = 8;
  localparam int unsigned EVENT_W = 5;

  // Byte offsets on the register bus
  localparam logic [11:0] SERIAL_IRQ_ENABLE_OFFSET = 12'h000;
  localparam logic [11:0] TIMER_IRQ_ENABLE_OFFSET = 12'h004;
  localparam logic [11:0] LOGIC_CELL_GATE_IRQ_ENABLE_OFFSET = 12'h008;
  localparam logic [11:0] CAPTURE_COMPARE_IRQ_ENABLE_OFFSET = 12'h00C;
  localparam logic [11:0] IRQ_CONTROL_OFFSET = 12'h010;
  localparam logic [11:0] EVENT_STATUS_OFFSET = 12'h014;
  localparam logic [11:0] EVENT_MASK_OFFSET = 12'h018;
  localparam logic [11:0] FLAG_VIEW_OFFSET = 12'h01C;
  localparam logic [11:0] PENDING_VIEW_OFFSET = 12'h020;

  // Serial enable register fields
  localparam int unsigned SERIAL_RX_IRQ_EN_POS = 5;
  localparam int unsigned SERIAL_TX_IRQ_EN_POS = 4;
  localparam int unsigned PORT2_COLLISION_IRQ_EN_POS = 3;
  localparam int unsigned PORT2_SERIAL_IRQ_EN_POS = 2;
  localparam int unsigned PORT1_COLLISION_IRQ_EN_POS = 1;
  localparam int unsigned PORT1_SERIAL_IRQ_EN_POS = 0;

  // Timer enable register fields
  localparam int unsigned TIMER_C_MATCH_IRQ_EN_POS = 5;
  localparam int unsigned WIDE_TIMER_C_OVF_IRQ_EN_POS = 4;
  localparam int unsigned TIMER_B_MATCH_IRQ_EN_POS = 3;
  localparam int unsigned WIDE_TIMER_B_OVF_IRQ_EN_POS = 2;
  localparam int unsigned TIMER_A_MATCH_IRQ_EN_POS = 1;
  localparam int unsigned WIDE_TIMER_A_OVF_IRQ_EN_POS = 0;

  // Logic cell and gate enable register fields
  localparam int unsigned LOGIC_CELL_D_IRQ_EN_POS = 7;
  localparam int unsigned LOGIC_CELL_C_IRQ_EN_POS = 6;
  localparam int unsigned LOGIC_CELL_B_IRQ_EN_POS = 5;
  localparam int unsigned LOGIC_CELL_A_IRQ_EN_POS = 4;
  localparam int unsigned WIDE_TIMER_C_GATE_IRQ_EN_POS = 2;
  localparam int unsigned WIDE_TIMER_B_GATE_IRQ_EN_POS = 1;
  localparam int unsigned WIDE_TIMER_A_GATE_IRQ_EN_POS = 0;

  // Capture/compare enable register fields
  localparam int unsigned CAPCMP_E_IRQ_EN_POS = 4;
  localparam int unsigned CAPCMP_D_IRQ_EN_POS = 3;
  localparam int unsigned CAPCMP_C_IRQ_EN_POS = 2;
  localparam int unsigned CAPCMP_B_IRQ_EN_POS = 1;
  localparam int unsigned CAPCMP_A_IRQ_EN_POS = 0;

  // Implemented bits per enable register
  localparam logic [7:0] SERIAL_IMPL_MASK = 8'h3F;
  localparam logic [7:0] TIMER_IMPL_MASK = 8'h3F;
  localparam logic [7:0] LOGIC_CELL_GATE_IMPL_MASK = 8'hF7;
  localparam logic [7:0] CAPTURE_COMPARE_IMPL_MASK = 8'h1F;

  // Control register fields
  localparam int unsigned GLOBAL_IRQ_EN_POS = 0;
  localparam int unsigned PERIPHERAL_IRQ_GROUP_EN_POS = 1;

  // Event status bit of the request output rising
  localparam int unsigned REQ_RISE_EVENT_POS = 4;

  localparam logic [7:0] ENABLE_RESET = 8'h00;
  localparam logic [1:0] CONTROL_RESET = 2'h0;
  localparam logic [4:0] EVENT_MASK_RESET = 5'h00;

endpackage

/* design/irq_enable_lane.sv */
// One enable register lane: masks flags by enables and flags a new pending source
module irq_enable_lane
  import irq_enable_pkg::*;
#(
  parameter int unsigned WIDTH = 8
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [WIDTH-1:0] flags,
  input wire logic [WIDTH-1:0] enables,
  output logic [WIDTH-1:0] pending,
  output logic any_pending,
  output logic new_pending
);

  logic [WIDTH-1:0] pending_last_ff;

  initial
  begin
    if (WIDTH < 1)
      $error("irq_enable_lane needs WIDTH of at least 1");
  end

  assign pending = flags & enables;
  assign any_pending = |pending;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pending_last_ff <= '0;
    else
      pending_last_ff <= pending;
  end

  // Any source that newly becomes pending, not only the first
  assign new_pending = |(pending & ~pending_last_ff);

endmodule

/* design/irq_event_status.sv */
// Sticky event status with write-one-to-clear, mask and level interrupt
module irq_event_status
  import irq_enable_pkg::*;
#(
  parameter int unsigned WIDTH = 5
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [WIDTH-1:0] event_set,
  input wire logic [WIDTH-1:0] clear_ones,
  input wire logic clear_we,
  input wire logic [WIDTH-1:0] mask_wdata,
  input wire logic mask_we,
  output logic [WIDTH-1:0] status,
  output logic [WIDTH-1:0] mask,
  output logic irq
);

  logic [WIDTH-1:0] status_ff;
  logic [WIDTH-1:0] mask_ff;
  logic [WIDTH-1:0] nxt_status;

  initial
  begin
    if (WIDTH < 1 || WIDTH > EVENT_W)
      $error("irq_event_status needs WIDTH from 1 to EVENT_W");
  end

  // Set wins over a clear in the same cycle, so no event is lost
  always_comb
  begin
    nxt_status = status_ff;
    if (clear_we)
      nxt_status = nxt_status & ~clear_ones;
    nxt_status = nxt_status | event_set;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      status_ff <= '0;
    else
      status_ff <= nxt_status;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      mask_ff <= EVENT_MASK_RESET[WIDTH-1:0];
    else if (mask_we)
      mask_ff <= mask_wdata;
  end

  assign status = status_ff;
  assign mask = mask_ff;
  assign irq = |(status_ff & mask_ff);

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_event_set_wins: assert property (
    (event_set != '0) |=>
      ((status_ff & $past(event_set)) == $past(event_set)))
    else $error("event lost against a clear");

  a_status_sticky: assert property (
    !clear_we |=>
      ((status_ff & $past(status_ff)) == $past(status_ff)))
    else $error("event status dropped without a clear");

  a_irq_follows_mask: assert property (irq == ((status_ff & mask_ff) != '0))
    else $error("interrupt line disagrees with status and mask");

endmodule

/* design/peripheral_irq_enable_bank.sv */
// Peripheral interrupt enable bank with APB register access and request gating
// Notes on behaviour
// - Serial register: receive enable at bit 5, transmit enable at bit 4, bits 7:6 unused.
// - The transmit interrupt passes only while the transmit enable bit is one.
// - Collision enables of serial ports two and one sit at bits 3 and 1, one enables.
// - General enables of serial ports two and one sit at bits 2 and 0, one enables.
// - Match enables of the three narrow timers sit at bits 5, 3 and 1 of the timer register.
// - Overflow enables of the three wide timers sit at bits 4, 2 and 0 of the timer register.
// - Logic cell enables four down to one sit at bits 7 to 4 of the cell and gate register.
// - Gate acquisition enables sit at bits 2 to 0 of that register, bit 3 unused.
// - Capture/compare enables five down to one sit at bits 4 to 0, bits 7:5 unused.
// - A source requests only while both its own enable and the group enable are set.
// - Every implemented enable bit is zero after any reset.
// - Unused bit positions read zero and ignore writes.
// - The group enable at one lets all enabled sources through while the global enable is one, and at zero blocks them all.
// - Flags are seen as they are, whatever the enables and the global enable hold.
module peripheral_irq_enable_bank
  import irq_enable_pkg::*;
#(
  parameter int unsigned ADDR_W = 12
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] serial_flags,
  input wire logic [7:0] timer_flags,
  input wire logic [7:0] logic_cell_gate_flags,
  input wire logic [7:0] capture_compare_flags,
  output logic periph_irq_req,
  output logic bank_irq
);

  typedef logic [NUM_ENABLE_REGS-1:0][ENABLE_W-1:0] enable_bank_t;

  localparam enable_bank_t IMPL_MASKS = {CAPTURE_COMPARE_IMPL_MASK, LOGIC_CELL_GATE_IMPL_MASK,
                                         TIMER_IMPL_MASK, SERIAL_IMPL_MASK};

  enable_bank_t enable_ff;
  enable_bank_t flags_all;
  enable_bank_t pending_all;
  logic [NUM_ENABLE_REGS-1:0] lane_any;
  logic [NUM_ENABLE_REGS-1:0] lane_new;
  logic [1:0] control_ff;
  logic [31:0] prdata_ff;
  logic [31:0] nxt_prdata;
  logic req_last_ff;
  logic [EVENT_W-1:0] status;
  logic [EVENT_W-1:0] event_mask;
  logic [EVENT_W-1:0] event_set;
  logic wr_access;
  logic rd_setup;
  logic addr_hit;
  logic global_irq_en;
  logic peripheral_irq_group_en;

  initial
  begin
    if (ADDR_W < 6 || ADDR_W > 12)
      $error("peripheral_irq_enable_bank needs ADDR_W from 6 to 12");
  end

  // Index of the enable register at an address, or NUM_ENABLE_REGS when none
  function automatic int unsigned enable_index(input logic [ADDR_W-1:0] addr);
    logic [11:0] a;
    a = 12'(addr);
    case (a)
      SERIAL_IRQ_ENABLE_OFFSET: enable_index = 0;
      TIMER_IRQ_ENABLE_OFFSET: enable_index = 1;
      LOGIC_CELL_GATE_IRQ_ENABLE_OFFSET: enable_index = 2;
      CAPTURE_COMPARE_IRQ_ENABLE_OFFSET: enable_index = 3;
      default: enable_index = NUM_ENABLE_REGS;
    endcase
  endfunction

  function automatic logic is_mapped(input logic [ADDR_W-1:0] addr);
    logic [11:0] a;
    a = 12'(addr);
    is_mapped = (enable_index(addr) < NUM_ENABLE_REGS) || a == IRQ_CONTROL_OFFSET ||
                a == EVENT_STATUS_OFFSET || a == EVENT_MASK_OFFSET ||
                a == FLAG_VIEW_OFFSET || a == PENDING_VIEW_OFFSET;
  endfunction

  assign flags_all = {capture_compare_flags, logic_cell_gate_flags, timer_flags, serial_flags};
  assign global_irq_en = control_ff[GLOBAL_IRQ_EN_POS];
  assign peripheral_irq_group_en = control_ff[PERIPHERAL_IRQ_GROUP_EN_POS];

  // Bus handshake: zero wait states, unmapped addresses answer with an error
  assign addr_hit = is_mapped(paddr);
  assign pready = psel & penable;
  assign pslverr = psel & penable & ~addr_hit;
  assign wr_access = psel & penable & pwrite & addr_hit & pstrb[0];
  assign rd_setup = psel & ~penable & ~pwrite;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_ENABLE_REGS; gi++)
    begin : g_enable
      // Unused positions are masked on write so they always read zero
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          enable_ff[gi] <= ENABLE_RESET;
        else if (wr_access && enable_index(paddr) == gi)
          enable_ff[gi] <= pwdata[ENABLE_W-1:0] & IMPL_MASKS[gi];
      end

      irq_enable_lane #(
        .WIDTH(ENABLE_W)
      ) u_lane (
        .pclk(pclk),
        .presetn(presetn),
        .flags(flags_all[gi]),
        .enables(enable_ff[gi]),
        .pending(pending_all[gi]),
        .any_pending(lane_any[gi]),
        .new_pending(lane_new[gi])
      );
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      control_ff <= CONTROL_RESET;
    else if (wr_access && 12'(paddr) == IRQ_CONTROL_OFFSET)
      control_ff <= pwdata[1:0];
  end

  // Each source needs its own enable, the group enable and the global enable
  assign periph_irq_req = global_irq_en & peripheral_irq_group_en & (|lane_any);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      req_last_ff <= 1'b0;
    else
      req_last_ff <= periph_irq_req;
  end

  always_comb
  begin
    event_set = '0;
    event_set[NUM_ENABLE_REGS-1:0] = lane_new;
    event_set[REQ_RISE_EVENT_POS] = periph_irq_req & ~req_last_ff;
  end

  irq_event_status #(
    .WIDTH(EVENT_W)
  ) u_events (
    .pclk(pclk),
    .presetn(presetn),
    .event_set(event_set),
    .clear_ones(pwdata[EVENT_W-1:0]),
    .clear_we(wr_access && 12'(paddr) == EVENT_STATUS_OFFSET),
    .mask_wdata(pwdata[EVENT_W-1:0]),
    .mask_we(wr_access && 12'(paddr) == EVENT_MASK_OFFSET),
    .status(status),
    .mask(event_mask),
    .irq(bank_irq)
  );

  // Read data is captured in the setup cycle so prdata comes from a flop
  always_comb
  begin
    nxt_prdata = '0;
    if (enable_index(paddr) < NUM_ENABLE_REGS)
      nxt_prdata[ENABLE_W-1:0] = enable_ff[enable_index(paddr)];
    else
    begin
      case (12'(paddr))
        IRQ_CONTROL_OFFSET: nxt_prdata[1:0] = control_ff;
        EVENT_STATUS_OFFSET: nxt_prdata[EVENT_W-1:0] = status;
        EVENT_MASK_OFFSET: nxt_prdata[EVENT_W-1:0] = event_mask;
        FLAG_VIEW_OFFSET: nxt_prdata = flags_all;
        PENDING_VIEW_OFFSET: nxt_prdata = pending_all;
        default: nxt_prdata = '0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata_ff <= '0;
    else if (rd_setup)
      prdata_ff <= nxt_prdata;
  end

  assign prdata = prdata_ff;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // Bus phases and source patterns that the checks below start from
  sequence s_enable_write;
    wr_access && enable_index(paddr) < NUM_ENABLE_REGS;
  endsequence

  sequence s_read_setup(logic [11:0] off);
    rd_setup && 12'(paddr) == off;
  endsequence

  // Unmapped address or no strobe on the data byte
  sequence s_dropped_write;
    psel && penable && pwrite && (!addr_hit || !pstrb[0]);
  endsequence

  sequence s_tx_alone_masked;
    serial_flags == 8'h10 && timer_flags == 8'h00 &&
    logic_cell_gate_flags == 8'h00 && capture_compare_flags == 8'h00 &&
    !enable_ff[0][SERIAL_TX_IRQ_EN_POS];
  endsequence

  sequence s_tx_enabled_open;
    serial_flags[SERIAL_TX_IRQ_EN_POS] && enable_ff[0][SERIAL_TX_IRQ_EN_POS] &&
    control_ff == 2'h3;
  endsequence

  a_enable_write_mask: assert property (
    s_enable_write |=>
      enable_ff[$past(enable_index(paddr))] ==
      ($past(pwdata[7:0]) & IMPL_MASKS[$past(enable_index(paddr))]))
    else $error("enable register did not take the masked write");

  a_serial_unused_zero: assert property (
    s_enable_write |=>
      (enable_ff[0][7:6] == 2'h0) [*2])
    else $error("serial enable unused bits not zero");

  a_unused_bits_zero: assert property (
    (enable_ff & ~IMPL_MASKS) == '0)
    else $error("an unused enable position holds a one");

  a_dropped_write: assert property (
    s_dropped_write |=>
      ($stable(enable_ff) && $stable(control_ff)))
    else $error("refused write changed a register");

  a_ready_no_wait: assert property (
    (psel && penable) |->
      (pready && (pslverr == !addr_hit)))
    else $error("access phase answered late or with a wrong error");

  a_tx_masked: assert property (
    s_tx_alone_masked |-> !periph_irq_req)
    else $error("transmit interrupt passed while its enable is clear");

  a_tx_allowed: assert property (
    s_tx_enabled_open |-> periph_irq_req)
    else $error("enabled transmit interrupt did not request");

  a_group_blocks: assert property (
    !peripheral_irq_group_en |-> !periph_irq_req)
    else $error("request raised while group enable is clear");

  a_group_passes: assert property (
    (global_irq_en && peripheral_irq_group_en && ((flags_all & enable_ff) != '0)) |->
      periph_irq_req)
    else $error("enabled source blocked while both enables are set");

  a_global_blocks: assert property (
    !global_irq_en |-> !periph_irq_req)
    else $error("request raised while global enable is clear");

  a_request_needs_source: assert property (
    periph_irq_req |->
      ((flags_all & enable_ff) != '0))
    else $error("request raised with no enabled source flag");

  a_rise_event: assert property (
    $rose(periph_irq_req) |=>
      status[REQ_RISE_EVENT_POS])
    else $error("request rise not recorded in the event status");

  a_lane_event: assert property (
    (lane_new != '0) |=>
      ((status[NUM_ENABLE_REGS-1:0] & $past(lane_new)) == $past(lane_new)))
    else $error("newly pending source not recorded in the event status");

  a_reset_clear: assert property (
    $rose(presetn) |->
      (enable_ff == '0 && control_ff == 2'h0))
    else $error("enable bits not cleared by reset");

  a_unused_read_zero: assert property (
    s_read_setup(CAPTURE_COMPARE_IRQ_ENABLE_OFFSET) |=>
      prdata[31:5] == 27'h0)
    else $error("unused capture/compare bits read non-zero");

  a_flag_view_raw: assert property (
    s_read_setup(FLAG_VIEW_OFFSET) |=>
      prdata == $past(flags_all))
    else $error("flag view altered by the enables");

  a_pending_view: assert property (
    s_read_setup(PENDING_VIEW_OFFSET) |=>
      prdata == $past(flags_all & enable_ff))
    else $error("pending view differs from flags under enables");

  // Read data is a flop: it may only move at a read setup
  a_read_data_holds: assert property (
    !rd_setup |=>
      $stable(prdata))
    else $error("read data changed outside a read setup");

endmodule

/* verif/flag_source_model.sv */
// Peripheral flag sources that face the enable bank
module flag_source_model
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic load,
  input wire logic [1:0] sel,
  input wire logic [7:0] pattern,
  output logic [31:0] flags
);
  timeunit 1ns;
  timeprecision 100ps;

  // Flags follow their sources, blind to every enable
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      flags <= 32'h0;
    else if (load)
      flags[sel*8 +: 8] <= pattern;
  end
endmodule

/* verif/peripheral_irq_enable_bank_bench.sv */
// Self-checking bench of the interrupt enable bank
module peripheral_irq_enable_bank_bench;
  import irq_enable_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;

  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, req, birq, load;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, flags, rdv;
  logic [3:0] pstrb;
  logic [1:0] sel;
  logic [7:0] pattern;
  logic err;
  int fail_count, checks_done;
  logic [11:0] offs [4] = '{SERIAL_IRQ_ENABLE_OFFSET, TIMER_IRQ_ENABLE_OFFSET,
    LOGIC_CELL_GATE_IRQ_ENABLE_OFFSET, CAPTURE_COMPARE_IRQ_ENABLE_OFFSET};
  logic [7:0] impl [4] = '{SERIAL_IMPL_MASK, TIMER_IMPL_MASK, LOGIC_CELL_GATE_IMPL_MASK,
    CAPTURE_COMPARE_IMPL_MASK};

  peripheral_irq_enable_bank uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .serial_flags(flags[7:0]),
    .timer_flags(flags[15:8]), .logic_cell_gate_flags(flags[23:16]),
    .capture_compare_flags(flags[31:24]), .periph_irq_req(req), .bank_irq(birq));
  flag_source_model far_side (.pclk(pclk), .presetn(presetn), .load(load), .sel(sel),
    .pattern(pattern), .flags(flags));

  always #2.5 pclk = ~pclk;

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Holds the request until pready is seen, never assumes a latency
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
    input logic [3:0] s);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    rdv = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // A write lands at the edge just seen; let it settle before any check
    @(posedge pclk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 4'hF);
  endtask

  task automatic rd(input logic [11:0] a);
    apb(1'b0, a, 32'h0, 4'h0);
  endtask

  task automatic set_flags(input logic [1:0] r, input logic [7:0] p);
    @(posedge pclk);
    sel <= r;
    pattern <= p;
    load <= 1'b1;
    @(posedge pclk);
    load <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic t_reset();
    chk("req after reset", 32'h0, {31'h0, req});
    chk("irq after reset", 32'h0, {31'h0, birq});
    for (int i = 0; i < 4; i++)
    begin
      rd(offs[i]);
      chk("enable reset", 32'h0, rdv);
    end
  endtask

  // Unused bits must drop writes; a write without byte 0 strobe is ignored
  task automatic t_layout();
    for (int i = 0; i < 4; i++)
    begin
      wr(offs[i], 32'hFFFFFFFF);
      rd(offs[i]);
      chk("enable layout", {24'h0, impl[i]}, rdv);
      apb(1'b1, offs[i], 32'h0, 4'hE);
      rd(offs[i]);
      chk("strobe ignored", {24'h0, impl[i]}, rdv);
      wr(offs[i], 32'h0);
    end
  endtask

  task automatic t_unmapped();
    wr(12'h024, 32'hFFFFFFFF);
    chk("unmapped write err", 32'h1, {31'h0, err});
    rd(12'h024);
    chk("unmapped read err", 32'h1, {31'h0, err});
    chk("unmapped read data", 32'h0, rdv);
    rd(12'h002);
    chk("misaligned err", 32'h1, {31'h0, err});
  endtask

  // Each bit masks its own source only, under group and global enables
  task automatic t_gate();
    logic [7:0] one;
    for (int r = 0; r < 4; r++)
      for (int b = 0; b < 8; b++)
      begin
        one = 8'h01 << b;
        wr(IRQ_CONTROL_OFFSET, 32'h3);
        wr(offs[r], {24'h0, one});
        set_flags(r[1:0], ~one);
        chk("other flags masked", 32'h0, {31'h0, req});
        set_flags(r[1:0], one);
        chk("source passes", {31'h0, |(one & impl[r])}, {31'h0, req});
        rd(PENDING_VIEW_OFFSET);
        chk("pending view", {24'h0, one & impl[r]} << (8 * r), rdv);
        wr(IRQ_CONTROL_OFFSET, 32'h1);
        chk("group blocks", 32'h0, {31'h0, req});
        wr(IRQ_CONTROL_OFFSET, 32'h2);
        chk("global blocks", 32'h0, {31'h0, req});
        wr(IRQ_CONTROL_OFFSET, 32'h3);
        wr(offs[r], 32'h0);
        chk("enable off masks", 32'h0, {31'h0, req});
        rd(FLAG_VIEW_OFFSET);
        chk("raw flag seen", {24'h0, one} << (8 * r), rdv);
        set_flags(r[1:0], 8'h00);
      end
  endtask

  task automatic t_event();
    wr(IRQ_CONTROL_OFFSET, 32'h3);
    wr(EVENT_STATUS_OFFSET, 32'h1F);
    wr(EVENT_MASK_OFFSET, 32'h10);
    wr(offs[0], 32'h10);
    chk("irq idle", 32'h0, {31'h0, birq});
    set_flags(2'd0, 8'h10);
    chk("tx request", 32'h1, {31'h0, req});
    // Status is set one edge after the request rises
    @(posedge pclk);
    chk("irq raised", 32'h1, {31'h0, birq});
    rd(EVENT_STATUS_OFFSET);
    chk("rise status", 32'h11, rdv);
    rd(IRQ_CONTROL_OFFSET);
    chk("control readback", 32'h3, rdv);
    rd(EVENT_MASK_OFFSET);
    chk("mask readback", 32'h10, rdv);
    wr(EVENT_STATUS_OFFSET, 32'h10);
    chk("irq cleared", 32'h0, {31'h0, birq});
    wr(EVENT_STATUS_OFFSET, 32'h1F);
    set_flags(2'd0, 8'h00);
    wr(offs[0], 32'h0);
  endtask

  // A second reset in mid-run must clear what software set
  task automatic t_rereset();
    wr(IRQ_CONTROL_OFFSET, 32'h3);
    for (int i = 0; i < 4; i++)
      wr(offs[i], 32'hFF);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(IRQ_CONTROL_OFFSET);
    chk("control after reset", 32'h0, rdv);
    for (int i = 0; i < 4; i++)
    begin
      rd(offs[i]);
      chk("enable after reset", 32'h0, rdv);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial
  begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, load} = 4'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    pstrb = 4'h0;
    sel = 2'h0;
    pattern = 8'h00;
    fail_count = 0;
    checks_done = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_layout();
    t_unmapped();
    t_gate();
    t_event();
    t_rereset();
    wrap_up();
  end

  // About 1500 cycles of traffic expected
  initial
  begin
    repeat (20000) @(posedge pclk);
    fail_count++;
    wrap_up();
  end
endmodule
